// ### rtl/eeprom_slave.v
// Two-wire serial EEPROM target: bus decoder, byte write path, page buffer,
// self-timed programming and the read path, with a 32K x 8 array inside.
// Assumes scl, sda_in, write_protect and the straps are asynchronous pins;
// an outside pull-up resolves sda from sda_oe, and unconnected straps are pulled low.
//
// What this block does
// - Sample data on clock rise, change driven data on clock fall.
// - Unconnected chip-select straps count as low when matching.
// - Data line is open drain: pull low or release only.
// - Write-protect high blocks programming; low or open allows it.
// - Reads work whatever the write-protect level.
// - Array is 512 pages of 64 bytes, 15-bit word address.
// - Data falling with clock high is START; commands begin with it.
// - Data rising with clock high is STOP; commands end with it.
// - STOP after read gives standby now; after write, once programmed.
// - Acknowledge each received byte by pulling data low on ninth clock.
// - Standby right after power-up, before any command.
// - First byte after START is device address, top nibble 1010.
// - Next three bits must match straps, else stay silent, standby.
// - Eighth address bit: one reads, zero writes.
// - Write: two word-address bytes follow, each acknowledged.
// - Then one data byte is shifted in and acknowledged.
// - During programming, all bus inputs are ignored.
// - Programming finishes within 5 ms of the STOP.
// - Each write erases the location itself; no erase command.
// - Page writes increment only low six address bits, wrapping.
// - No device-address acknowledge while programming; normal once done.
// - Address counter holds last address plus one while powered.
`timescale 1ns/100ps
`include "eeprom_slave_regs.vh"

module eeprom_slave #(
  parameter WRITE_CYCLES = `EE_T_WRITE_US * `EE_CLK_MHZ
) (
  input wire clk_sys,
  input wire rstn,
  input wire scl,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire write_protect,
  input wire chip_select_strap_2,
  input wire chip_select_strap_1,
  input wire chip_select_strap_0,
  output wire standby,
  output wire write_busy
);

  // One-hot states of the bus engine.
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_DEV = 8'h02;
  localparam [7:0] ST_AHI = 8'h04;
  localparam [7:0] ST_ALO = 8'h08;
  localparam [7:0] ST_WDAT = 8'h10;
  localparam [7:0] ST_RDAT = 8'h20;
  localparam [7:0] ST_WAIT = 8'h40;
  localparam [7:0] ST_PROG = 8'h80;
  localparam [31:0] WR_LAST = WRITE_CYCLES - 1;

  reg [7:0] mem [0:`EE_MEM_BYTES-1];
  reg [7:0] page_buf [0:`EE_PAGE_BYTES-1];
  reg [5:0] sync1_ff;
  reg [5:0] sync2_ff;
  reg [1:0] prev_ff;
  reg [7:0] state_ff;
  reg [3:0] bit_cnt_ff;
  reg [7:0] rx_ff;
  reg [7:0] tx_ff;
  reg [6:0] addr_hi_ff;
  reg [`EE_ADDR_W-1:0] addr_ff;
  reg [8:0] page_row_ff;
  reg [63:0] valid_ff;
  reg wr_pend_ff;
  reg push_ff;
  reg [13:0] push_data_ff;
  reg drained_ff;
  reg [6:0] commit_idx_ff;
  reg [17:0] prog_cnt_ff;
  reg sda_out_ff;
  reg sda_oe_ff;
  reg standby_ff;
  reg write_busy_ff;

  wire scl_s;
  wire sda_s;
  wire wp_s;
  wire [2:0] strap_s;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire dev_match;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [13:0] fifo_out_data;
  wire pop_fire;
  wire commit_act;
  wire commit_we;
  wire time_up;

  assign sda_out = sda_out_ff;
  assign sda_oe = sda_oe_ff;
  assign standby = standby_ff;
  assign write_busy = write_busy_ff;

  // Two-stage synchronisers for every pin; only the second stage is read.
  // They reset to the idle bus pattern so that no false clock edge follows reset.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= 6'h30;
      sync2_ff <= 6'h30;
      prev_ff <= 2'h3;
    end else begin
      sync1_ff <= {scl, sda_in, write_protect, chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff[5:4];
    end
  end

  assign scl_s = sync2_ff[5];
  assign sda_s = sync2_ff[4];
  assign wp_s = sync2_ff[3];
  assign strap_s = sync2_ff[2:0];

  // Bus events found from the synchronised clock and data.
  assign scl_rise = scl_s & ~prev_ff[1];
  assign scl_fall = ~scl_s & prev_ff[1];
  assign start_det = scl_s & prev_ff[1] & prev_ff[0] & ~sda_s;
  assign stop_det = scl_s & prev_ff[1] & ~prev_ff[0] & sda_s;

  assign dev_match = (rx_ff[7:4] == `EE_DEV_TYPE) && (rx_ff[3:1] == strap_s);

  // The buffer drains into the page latch except while it is being committed.
  assign fifo_out_ready = ~((state_ff == ST_PROG) & drained_ff);
  assign pop_fire = fifo_out_valid & fifo_out_ready;
  assign commit_act = (state_ff == ST_PROG) & drained_ff & ~commit_idx_ff[6];
  assign commit_we = commit_act & valid_ff[commit_idx_ff[5:0]] & ~wp_s;
  assign time_up = ({14'h0000, prog_cnt_ff} >= WR_LAST);

  // Received bytes queue here with their page offset and drain into the page latch at once.
  ee_fifo #(
    .WIDTH(`EE_FIFO_WIDTH),
    .DEPTH(`EE_FIFO_DEPTH),
    .AW(`EE_FIFO_AW)
  ) u_wbuf (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_valid(push_ff),
    .in_ready(fifo_in_ready),
    .in_data(push_data_ff),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Page latch and array writes; the array keeps its contents without reset.
  always @(posedge clk_sys) begin
    if (pop_fire) begin
      page_buf[fifo_out_data[13:8]] <= fifo_out_data[7:0];
    end
    if (commit_we) begin
      mem[{page_row_ff, commit_idx_ff[5:0]}] <= page_buf[commit_idx_ff[5:0]];
    end
  end

  // Bus engine, byte sequencing and programming control.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
      addr_hi_ff <= 7'h00;
      addr_ff <= 15'h0000;
      page_row_ff <= 9'h000;
      valid_ff <= 64'h0000000000000000;
      wr_pend_ff <= 1'b0;
      push_ff <= 1'b0;
      push_data_ff <= 14'h0000;
      drained_ff <= 1'b0;
      commit_idx_ff <= 7'h00;
      prog_cnt_ff <= 18'h00000;
      sda_out_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      standby_ff <= 1'b1;
      write_busy_ff <= 1'b0;
    end else begin
      push_ff <= 1'b0;
      standby_ff <= (state_ff == ST_IDLE);
      write_busy_ff <= (state_ff == ST_PROG);
      sda_out_ff <= 1'b0;
      if (pop_fire) begin
        valid_ff[fifo_out_data[13:8]] <= 1'b1;
      end
      if (state_ff == ST_PROG) begin
        sda_oe_ff <= 1'b0;
        if (!time_up) begin
          prog_cnt_ff <= prog_cnt_ff + 18'h00001;
        end
        if (!drained_ff) begin
          if (!fifo_out_valid) begin
            drained_ff <= 1'b1;
          end
        end else if (!commit_idx_ff[6]) begin
          commit_idx_ff <= commit_idx_ff + 7'h01;
        end
        if (time_up && drained_ff && commit_idx_ff[6]) begin
          state_ff <= ST_IDLE;
        end
      end else if (start_det) begin
        state_ff <= ST_DEV;
        bit_cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
        wr_pend_ff <= 1'b0;
      end else if (stop_det) begin
        sda_oe_ff <= 1'b0;
        wr_pend_ff <= 1'b0;
        if (wr_pend_ff && !wp_s) begin
          state_ff <= ST_PROG;
          prog_cnt_ff <= 18'h00000;
          drained_ff <= 1'b0;
          commit_idx_ff <= 7'h00;
        end else begin
          state_ff <= ST_IDLE;
        end
      end else if (scl_rise && state_ff != ST_IDLE) begin
        if (bit_cnt_ff != `EE_BITS_PER_BYTE) begin
          rx_ff <= {rx_ff[6:0], sda_s};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end else begin
          bit_cnt_ff <= 4'h0;
          if (state_ff == ST_RDAT) begin
            if (sda_s) begin
              state_ff <= ST_WAIT;
            end else begin
              tx_ff <= mem[addr_ff];
              addr_ff <= addr_ff + 15'h0001;
            end
          end
        end
      end else if (scl_fall && state_ff != ST_IDLE) begin
        if (state_ff == ST_RDAT) begin
          if (bit_cnt_ff != `EE_BITS_PER_BYTE) begin
            sda_oe_ff <= ~tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
          end else begin
            sda_oe_ff <= 1'b0;
          end
        end else if (bit_cnt_ff == `EE_BITS_PER_BYTE) begin
          case (state_ff)
            ST_DEV: begin
              if (dev_match) begin
                sda_oe_ff <= 1'b1;
                if (rx_ff[0]) begin
                  // The first byte is fetched on the rise of this acknowledge clock.
                  state_ff <= ST_RDAT;
                end else begin
                  state_ff <= ST_AHI;
                end
              end else begin
                sda_oe_ff <= 1'b0;
                state_ff <= ST_IDLE;
              end
            end
            ST_AHI: begin
              addr_hi_ff <= rx_ff[6:0];
              sda_oe_ff <= 1'b1;
              state_ff <= ST_ALO;
            end
            ST_ALO: begin
              addr_ff <= {addr_hi_ff, rx_ff};
              page_row_ff <= {addr_hi_ff, rx_ff[7:6]};
              valid_ff <= 64'h0000000000000000;
              sda_oe_ff <= 1'b1;
              state_ff <= ST_WDAT;
            end
            ST_WDAT: begin
              if (fifo_in_ready) begin
                push_ff <= 1'b1;
                push_data_ff <= {addr_ff[5:0], rx_ff};
                addr_ff <= {addr_ff[14:6], addr_ff[5:0] + 6'h01};
                wr_pend_ff <= 1'b1;
                sda_oe_ff <= 1'b1;
              end else begin
                sda_oe_ff <= 1'b0;
                state_ff <= ST_WAIT;
              end
            end
            default: begin
              sda_oe_ff <= 1'b0;
            end
          endcase
        end else begin
          sda_oe_ff <= 1'b0;
        end
      end
    end
  end

endmodule

// ### rtl/eeprom_slave_regs.vh
// Constants shared by the two-wire EEPROM target and its write buffer.
// Assumes a 50 MHz system clock that oversamples the serial bus pins.
`ifndef EEPROM_SLAVE_REGS_VH
`define EEPROM_SLAVE_REGS_VH

// Fixed upper nibble of the device address word.
`define EE_DEV_TYPE 4'hA
// Word address width and page geometry.
`define EE_ADDR_W 15
`define EE_PAGE_BYTES 64
`define EE_PAGE_BITS 6
`define EE_PAGES 512
`define EE_MEM_BYTES 32768
// Rising edges in one byte before the acknowledge clock.
`define EE_BITS_PER_BYTE 4'h8
// Write buffer geometry: six offset bits plus eight data bits.
`define EE_FIFO_WIDTH 14
`define EE_FIFO_DEPTH 16
`define EE_FIFO_AW 4
// Self-timed programming time in microseconds and the clock rate.
`define EE_T_WRITE_US 5000
`define EE_CLK_MHZ 50

`endif

// ### rtl/ee_fifo.v
// Synchronous FIFO with valid and ready on both sides.
// Assumes both sides run on the same clock; full and empty come from a fill count.
`timescale 1ns/100ps

module ee_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;
  localparam [AW:0] FULL_COUNT = DEPTH[AW:0];

  // Full and empty are honest: they follow the fill count exactly.
  assign in_ready = (count_ff != FULL_COUNT);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data = store[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset; only the pointers and the fill count carry control state.
  always @(posedge clk_sys) begin
    if (push) begin
      store[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push & ~pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop & ~push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule

// ### test/eeprom_slave_sva.sv
// Checker on the ports of the two-wire EEPROM target.
// Assumes it is bound to eeprom_slave and sees its pins by name.
`timescale 1ns/100ps
module eeprom_slave_sva #(
  parameter WRITE_CYCLES = 200
) (
  input wire clk_sys,
  input wire rstn,
  input wire scl,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire write_protect,
  input wire chip_select_strap_2,
  input wire chip_select_strap_1,
  input wire chip_select_strap_0,
  input wire standby,
  input wire write_busy
);
  // All checks run on the system clock and rest during reset.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_open_drain: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data line driven high");
  a_fall_only: assert property ($changed(sda_oe) |-> !$past(scl))
    else $error("data moved while clock high");
  a_idle_silent: assert property (standby |-> !sda_oe)
    else $error("data driven in standby");
  a_busy_quiet: assert property (write_busy |-> !sda_oe)
    else $error("answer given while programming");
  a_busy_not_idle: assert property (write_busy |-> !standby)
    else $error("standby while programming");
  a_stop_starts: assert property ($rose(write_busy) |-> scl && sda_in)
    else $error("programming began without stop");
  a_protect_holds: assert property (write_protect |-> !$rose(write_busy))
    else $error("programming under write protect");
  a_cycle_bound: assert property ($rose(write_busy) |-> write_busy [*8] ##[1:1000] !write_busy)
    else $error("programming time out of bounds");
  a_end_standby: assert property ($fell(write_busy) |-> ##[0:1] standby)
    else $error("no standby after programming");
  a_reset_idle: assert property ($rose(rstn) |-> standby && !write_busy && !sda_oe)
    else $error("not idle after reset");
endmodule

// ### test/bus_controller_model.sv
// Bus controller model: drives the serial clock and pulls the data line.
// Assumes an outside pull-up resolves the data line into sda_line.
`timescale 1ns/100ps
module bus_controller_model (
  input wire clk_sys,
  input wire sda_line,
  output reg scl,
  output reg sda_low
);
  // The clock stands high and the data line is released while idle.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    hold(3);
    sda_low <= ~b;
    hold(2);
    scl <= 1'b1;
    hold(2);
    r = sda_line;
    hold(1);
  endtask
  task automatic start_cond;
    scl <= 1'b0;
    hold(3);
    sda_low <= 1'b0;
    hold(2);
    scl <= 1'b1;
    hold(3);
    sda_low <= 1'b1;
    hold(3);
  endtask
  task automatic stop_cond;
    scl <= 1'b0;
    hold(3);
    sda_low <= 1'b1;
    hold(2);
    scl <= 1'b1;
    hold(3);
    sda_low <= 1'b0;
    hold(6);
  endtask
  // MSB first, ack read on ninth clock.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Reads a byte and answers with an ack or, for the last byte, a nack.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// ### test/eeprom_slave_bench.sv
// Self-checking bench for the two-wire EEPROM target write and read paths.
// Assumes the bus controller model and the port checker are compiled first.
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %0t got %h want %h", $time, got, exp); end end
module eeprom_slave_bench;
  reg clk_sys;
  reg rstn;
  reg write_protect;
  reg [2:0] straps;
  wire scl, sda_low, sda_oe, sda_out, standby, write_busy, sda_in;
  int n_errors;
  int comparisons;
  int cycles = 0;
  // The pull-up resolves every party's pull into one line.
  assign sda_in = ~(sda_low | (sda_oe & ~sda_out));
  eeprom_slave #(.WRITE_CYCLES(200)) i_eeprom_slave (.clk_sys(clk_sys), .rstn(rstn), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
    .chip_select_strap_2(straps[2]), .chip_select_strap_1(straps[1]), .chip_select_strap_0(straps[0]),
    .standby(standby), .write_busy(write_busy));
  bus_controller_model i_bus_controller_model (.clk_sys(clk_sys), .sda_line(sda_in), .scl(scl), .sda_low(sda_low));
  // Clock generator and hang limit.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      final_report;
    end
  end
  task automatic final_report;
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Start, device address for writing and both word address bytes.
  task automatic send_addr(input logic [14:0] a);
    logic k;
    i_bus_controller_model.start_cond;
    i_bus_controller_model.wr_byte({4'hA, straps, 1'b0}, k);
    `CHK(k, 1'b1)
    i_bus_controller_model.wr_byte({1'b1, a[14:8]}, k);
    `CHK(k, 1'b1)
    i_bus_controller_model.wr_byte(a[7:0], k);
    `CHK(k, 1'b1)
  endtask
  task automatic read_at(input logic [14:0] a, output logic [7:0] d);
    logic k;
    send_addr(a);
    i_bus_controller_model.start_cond;
    i_bus_controller_model.wr_byte({4'hA, straps, 1'b1}, k);
    `CHK(k, 1'b1)
    i_bus_controller_model.rd_byte(1'b1, d);
    i_bus_controller_model.stop_cond;
  endtask
  // Writes n bytes from the top of dat, then waits out programming.
  task automatic write_at(input logic [14:0] a, input logic [15:0] dat, input int n);
    logic k;
    send_addr(a);
    for (int i = 0; i < n; i++) begin
      i_bus_controller_model.wr_byte(dat[15-8*i -: 8], k);
      `CHK(k, 1'b1)
    end
    i_bus_controller_model.stop_cond;
    `CHK(write_busy, ~write_protect)
    i_bus_controller_model.start_cond;
    i_bus_controller_model.wr_byte({4'hA, straps, 1'b0}, k);
    `CHK(k, write_protect)
    i_bus_controller_model.stop_cond;
    for (int i = 0; i < 400 && write_busy; i++) @(posedge clk_sys);
    `CHK(write_busy, 1'b0)
    `CHK(standby, 1'b1)
  endtask
  task automatic sc_byte_write;
    logic [7:0] d;
    write_at(15'h1234, 16'h5AA5, 2);
    read_at(15'h1234, d);
    `CHK(d, 8'h5A)
  endtask
  // Sequential read: the counter walks on after each acknowledged byte.
  task automatic sc_seq_read;
    logic k;
    logic [7:0] d;
    send_addr(15'h1234);
    i_bus_controller_model.start_cond;
    i_bus_controller_model.wr_byte({4'hA, straps, 1'b1}, k);
    `CHK(k, 1'b1)
    i_bus_controller_model.rd_byte(1'b0, d);
    `CHK(d, 8'h5A)
    i_bus_controller_model.rd_byte(1'b1, d);
    `CHK(d, 8'hA5)
    i_bus_controller_model.stop_cond;
  endtask
  task automatic sc_page_wrap;
    logic [7:0] d;
    write_at(15'h013F, 16'hC33C, 2);
    read_at(15'h0100, d);
    `CHK(d, 8'h3C)
    read_at(15'h013F, d);
    `CHK(d, 8'hC3)
  endtask
  task automatic sc_wrong_addr;
    logic k;
    logic [7:0] d;
    i_bus_controller_model.start_cond;
    i_bus_controller_model.wr_byte({4'hA, ~straps, 1'b0}, k);
    `CHK(k, 1'b0)
    i_bus_controller_model.start_cond;
    i_bus_controller_model.wr_byte({4'hB, straps, 1'b0}, k);
    `CHK(k, 1'b0)
    i_bus_controller_model.stop_cond;
    `CHK(standby, 1'b1)
    straps <= 3'h0;
    read_at(15'h1234, d);
    `CHK(d, 8'h5A)
    straps <= 3'h5;
  endtask
  task automatic sc_protect;
    logic [7:0] d;
    write_protect <= 1'b1;
    write_at(15'h1234, 16'hFF00, 1);
    read_at(15'h1234, d);
    `CHK(d, 8'h5A)
    write_protect <= 1'b0;
  endtask
  task automatic sc_abort;
    logic k;
    logic [7:0] d;
    send_addr(15'h1234);
    i_bus_controller_model.wr_byte(8'h77, k);
    i_bus_controller_model.start_cond;
    i_bus_controller_model.stop_cond;
    `CHK(write_busy, 1'b0)
    read_at(15'h1234, d);
    `CHK(d, 8'h5A)
  endtask
  // Reset, then the scenarios in turn.
  initial begin
    rstn = 1'b0;
    write_protect = 1'b0;
    straps = 3'h5;
    n_errors = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_sys);
    `CHK(standby, 1'b1)
    rstn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    sc_byte_write;
    sc_seq_read;
    sc_page_wrap;
    sc_wrong_addr;
    sc_protect;
    sc_abort;
    final_report;
  end
endmodule
bind eeprom_slave eeprom_slave_sva #(.WRITE_CYCLES(WRITE_CYCLES)) i_eeprom_slave_sva (.clk_sys(clk_sys),
  .rstn(rstn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
  .chip_select_strap_2(chip_select_strap_2), .chip_select_strap_1(chip_select_strap_1),
  .chip_select_strap_0(chip_select_strap_0), .standby(standby), .write_busy(write_busy));
